// File: include/rmcfg_pkg.sv
// Package for the radio module configuration-mode block: register map,
// command codes, line-rate and mode timing constants.
// Assumes a single 100 MHz clock shared by both ends of the link.
package rmcfg_pkg;
    localparam int unsigned CLK_HZ        = 100_000_000; // System clock
    localparam int unsigned CFG_BAUD      = 9600;        // Fixed command rate
    localparam int unsigned BIT_CYCLES    = CLK_HZ / CFG_BAUD; // Round down
    localparam int unsigned MODE_DELAY_US = 1000;        // 1 ms mode settle
    localparam int unsigned MODE_CYCLES   = MODE_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned RECFG_CYCLES  = 64;          // Reconfiguration time

    // Register offsets
    localparam logic [7:0] REG_NODE_ADDR_HIGH = 8'h00;
    localparam logic [7:0] REG_NODE_ADDR_LOW  = 8'h01;
    localparam logic [7:0] REG_SERIAL_AIR_CFG = 8'h02;
    localparam int unsigned NUM_REGS          = 3;

    // Reset values
    localparam logic [7:0] RST_NODE_ADDR_HIGH = 8'h00;
    localparam logic [7:0] RST_NODE_ADDR_LOW  = 8'h00;
    localparam logic [7:0] RST_SERIAL_AIR_CFG = 8'h62; // 9600, 8N1, 2.4k

    // Field positions in the serial and air rate register
    localparam int unsigned BAUD_MSB   = 7;
    localparam int unsigned BAUD_LSB   = 5;
    localparam int unsigned PARITY_MSB = 4;
    localparam int unsigned PARITY_LSB = 3;
    localparam int unsigned AIR_MSB    = 2;
    localparam int unsigned AIR_LSB    = 0;

    // Command and reply codes
    localparam logic [7:0] CMD_WRITE_PERM = 8'hC0;
    localparam logic [7:0] CMD_READ       = 8'hC1;
    localparam logic [7:0] CMD_WRITE_TEMP = 8'hC2;
    localparam logic [7:0] RSP_HEADER     = 8'hC1;
    localparam logic [7:0] RSP_ERROR      = 8'hFF;
    localparam int unsigned ERR_LEN       = 3;

    localparam logic [15:0] BROADCAST_ADDR = 16'hFFFF;

    // Host register port offsets and interrupt bits
    localparam logic [3:0] HR_CTRL    = 4'h0;  // [0] sleep request
    localparam logic [3:0] HR_TXDATA  = 4'h1;  // Write pushes a command byte
    localparam logic [3:0] HR_RXDATA  = 4'h2;  // Last reply byte
    localparam logic [3:0] HR_STATUS  = 4'h3;  // Sticky events
    localparam logic [3:0] HR_CLEAR   = 4'h4;  // Write one to clear
    localparam logic [3:0] HR_ENABLE  = 4'h5;  // Interrupt enable
    localparam logic [3:0] HR_LINK    = 4'h6;  // [0] tx busy, [1] ready level
    localparam int unsigned EV_RX     = 0;     // Reply byte arrived
    localparam int unsigned EV_TXDONE = 1;     // Command byte sent
    localparam int unsigned EV_READY  = 2;     // Busy indicator rose
    localparam int unsigned NUM_EV    = 3;
endpackage : rmcfg_pkg

// File: include/rmcfg_if.sv
// Link between the radio module and its host controller: two mode-select
// pins, the two UART lines at 9600 8N1 and the busy indicator.
// Assumes both ends share clk; the lines are plain levels.
interface rmcfg_if;
    logic mode_select_low;   // Host drives; both high selects sleep
    logic mode_select_high;  // Host drives
    logic host_to_dev_txd;   // Host serial out, device serial in
    logic dev_to_host_txd;   // Device serial out, host serial in
    logic busy_n;            // Device drives; low while busy

    modport device (
        input  mode_select_low,
        input  mode_select_high,
        input  host_to_dev_txd,
        output dev_to_host_txd,
        output busy_n
    );
    modport host (
        output mode_select_low,
        output mode_select_high,
        output host_to_dev_txd,
        input  dev_to_host_txd,
        input  busy_n
    );
endinterface : rmcfg_if

// File: rtl/rmcfg_device.sv
// Device end of the configuration link: mode pin watch, command
// parser, three-register map and UART at the fixed command rate.
// Assumes the host keeps the link rules; pins are asynchronous.
module rmcfg_device #(
    parameter int unsigned MODE_CYC = rmcfg_pkg::MODE_CYCLES,
    parameter int unsigned BIT_CYC  = rmcfg_pkg::BIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    rmcfg_if.device          link,
    output logic             radio_enable,
    output logic             addr_filter_en,
    output logic [2:0]       user_baud_sel,
    output logic [1:0]       user_parity_sel,
    output logic [2:0]       air_rate_sel,
    output logic [16:0]      air_rate_bps
);
    typedef enum logic [2:0] {
        P_CMD, P_ADDR, P_LEN, P_DATA, P_REPLY
    } rmcfg_pst_t;

    // All device state except the registered outputs in one record
    typedef struct packed {
        logic [1:0]  msl_s;      // Two-flop sync, mode low
        logic [1:0]  msh;        // Two-flop sync, mode high
        logic [1:0]  rx_s;       // rx_s[0] stage one, rx_s[1] stage two
        logic        sleep;      // Applied mode is sleep
        logic [1:0]  mode_prev;  // Last sampled pin pair
        logic [19:0] settle;     // Mode change delay
        logic [7:0]  recfg;      // Reconfiguration counter
        logic        busy_n;
        logic [2:0][7:0] regs;   // Register file (permanent)
        logic [2:0][7:0] apl;    // Applied settings
        // Receiver
        logic        rx_act;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [7:0]  rx_sh;
        // Parser
        rmcfg_pst_t  pst;
        logic [7:0]  cmd;
        logic [7:0]  addr;
        logic [7:0]  len;
        logic [7:0]  idx;
        logic        bad;
        logic [2:0][7:0] wbuf;   // Data bytes of a write command
        // Transmitter
        logic [7:0]  tx_pos;     // Reply byte index
        logic [7:0]  tx_total;
        logic        tx_act;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_sh;
        logic        txd;
    } rmcfg_dev_t;

    rmcfg_dev_t q, d;

    // Byte for reply position; error reply is all FF
    function automatic logic [7:0] reply_byte(input rmcfg_dev_t s,
                                              input logic [7:0] pos);
        logic [7:0] a;
        a = s.addr + pos - 8'd3;
        if (s.bad) return rmcfg_pkg::RSP_ERROR;
        unique case (pos)
            8'd0:    return rmcfg_pkg::RSP_HEADER;
            8'd1:    return s.addr;
            8'd2:    return s.len;
            default: return (a < 8'(rmcfg_pkg::NUM_REGS)) ?
                            s.apl[a[1:0]] : 8'h00;
        endcase
    endfunction

    // Air rate decode in bits per second
    function automatic logic [16:0] air_bps(input logic [2:0] f);
        unique case (f)
            3'd3:    return 17'd4800;
            3'd4:    return 17'd9600;
            3'd5:    return 17'd19200;
            3'd6:    return 17'd38400;
            3'd7:    return 17'd62500;
            default: return 17'd2400;  // 000, 001, 010 all 2.4k
        endcase
    endfunction

    // Next-state logic
    always_comb begin
        logic       rx_done;
        logic [7:0] rx_byte;
        logic [1:0] pins;
        d = q;
        rx_done = 1'b0;
        rx_byte = q.rx_sh;
        // Two-flop synchronisers
        d.msl_s = {q.msl_s[0], link.mode_select_low};
        d.msh   = {q.msh[0], link.mode_select_high};
        d.rx_s  = {q.rx_s[0], link.host_to_dev_txd};
        pins    = {q.msh[1], q.msl_s[1]};

        // Mode change applies 1 ms after pins settle, once idle
        if (pins != q.mode_prev) begin
            d.mode_prev = pins;
            d.settle    = 20'(MODE_CYC);
        end else if (q.settle != 20'd0) begin
            if (!q.tx_act && !q.rx_act && q.pst != P_REPLY)
                d.settle = q.settle - 20'd1;
        end else if ((pins == 2'b11) != q.sleep) begin
            d.sleep = (pins == 2'b11);
            if (q.sleep) begin
                d.recfg  = 8'(rmcfg_pkg::RECFG_CYCLES);
                d.busy_n = 1'b0;
                d.apl    = q.regs;     // Reapply stored settings
            end
        end
        if (q.recfg != 8'd0) begin
            d.recfg = q.recfg - 8'd1;
            if (q.recfg == 8'd1)
                d.busy_n = 1'b1;
        end

        // Receiver at fixed 9600 8N1, sampled mid-bit
        if (!q.rx_act) begin
            if (!q.rx_s[1] && q.sleep) begin
                d.rx_act = 1'b1;
                d.rx_cnt = 16'(BIT_CYC / 2);
                d.rx_bit = 4'd0;
            end
        end else if (q.rx_cnt != 16'd0) begin
            d.rx_cnt = q.rx_cnt - 16'd1;
        end else begin
            d.rx_cnt = 16'(BIT_CYC - 1);
            d.rx_bit = q.rx_bit + 4'd1;
            if (q.rx_bit == 4'd0 && q.rx_s[1])
                d.rx_act = 1'b0;               // False start
            else if (q.rx_bit == 4'd9) begin
                d.rx_act = 1'b0;
                rx_done  = q.rx_s[1];          // Stop bit must be high
            end else if (q.rx_bit != 4'd0)
                d.rx_sh = {q.rx_s[1], q.rx_sh[7:1]};
        end

        // Command parser
        if (rx_done && q.pst != P_REPLY) begin
            unique case (q.pst)
                P_CMD: begin
                    d.cmd = rx_byte;
                    d.bad = !(rx_byte == rmcfg_pkg::CMD_WRITE_PERM ||
                              rx_byte == rmcfg_pkg::CMD_READ ||
                              rx_byte == rmcfg_pkg::CMD_WRITE_TEMP);
                    d.pst = d.bad ? P_REPLY : P_ADDR;
                end
                P_ADDR: begin
                    d.addr = rx_byte;
                    d.pst  = P_LEN;
                end
                P_LEN: begin
                    d.len = rx_byte;
                    d.idx = 8'd0;
                    // Range beyond the map is a format error
                    d.bad = (rx_byte == 8'd0) ||
                            ({1'b0, q.addr} + {1'b0, rx_byte} >
                             9'(rmcfg_pkg::NUM_REGS));
                    d.pst = (d.bad || q.cmd == rmcfg_pkg::CMD_READ) ?
                            P_REPLY : P_DATA;
                end
                P_DATA: begin
                    d.wbuf[q.idx[1:0]] = rx_byte;
                    d.idx = q.idx + 8'd1;
                    if (q.idx + 8'd1 == q.len) begin
                        d.pst = P_REPLY;
                        for (int i = 0; i < 3; i++) begin
                            if (8'(i) >= q.addr && 8'(i) < q.addr + q.len)
                            begin
                                d.apl[i] = (8'(i) - q.addr == q.idx) ?
                                    rx_byte : q.wbuf[i - int'(q.addr)];
                                if (q.cmd == rmcfg_pkg::CMD_WRITE_PERM)
                                    d.regs[i] = d.apl[i];
                            end
                        end
                    end
                end
                default: d.pst = P_CMD;
            endcase
            if (q.pst == P_CMD || d.pst == P_REPLY) begin
                d.tx_pos   = 8'd0;
                d.tx_total = d.bad ? 8'(rmcfg_pkg::ERR_LEN) : d.len + 8'd3;
            end
        end

        // Transmitter sends reply once the command is complete
        if (!q.tx_act) begin
            d.txd = 1'b1;
            if (q.pst == P_REPLY) begin
                if (q.tx_pos == q.tx_total) begin
                    d.pst = P_CMD;
                    d.bad = 1'b0;
                end else begin
                    d.tx_sh  = {1'b1, reply_byte(q, q.tx_pos), 1'b0};
                    d.tx_act = 1'b1;
                    d.tx_cnt = 16'(BIT_CYC - 1);
                    d.tx_bit = 4'd0;
                    d.tx_pos = q.tx_pos + 8'd1;
                end
            end
        end else begin
            d.txd = q.tx_sh[0];
            if (q.tx_cnt != 16'd0)
                d.tx_cnt = q.tx_cnt - 16'd1;
            else begin
                d.tx_cnt = 16'(BIT_CYC - 1);
                d.tx_sh  = {1'b1, q.tx_sh[9:1]};
                d.tx_bit = q.tx_bit + 4'd1;
                if (q.tx_bit == 4'd9)
                    d.tx_act = 1'b0;
            end
        end
        if (!q.sleep && !d.sleep) begin
            d.pst = P_CMD;   // Leaving sleep drops a partial command
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q           <= '0;
            q.mode_prev <= 2'b00;
            q.busy_n    <= 1'b1;
            q.txd       <= 1'b1;
            q.rx_s      <= 2'b11;
            q.pst       <= P_CMD;
            q.regs[0]   <= rmcfg_pkg::RST_NODE_ADDR_HIGH;
            q.regs[1]   <= rmcfg_pkg::RST_NODE_ADDR_LOW;
            q.regs[2]   <= rmcfg_pkg::RST_SERIAL_AIR_CFG;
            q.apl[0]    <= rmcfg_pkg::RST_NODE_ADDR_HIGH;
            q.apl[1]    <= rmcfg_pkg::RST_NODE_ADDR_LOW;
            q.apl[2]    <= rmcfg_pkg::RST_SERIAL_AIR_CFG;
        end else begin
            q <= d;
        end
    end

    // Registered outputs derived from applied settings, sleep and busy state
    always_ff @(posedge clk) begin
        if (rst) begin
            radio_enable    <= 1'b0;
            addr_filter_en  <= 1'b1;
            user_baud_sel   <= rmcfg_pkg::RST_SERIAL_AIR_CFG[
                                   rmcfg_pkg::BAUD_MSB:rmcfg_pkg::BAUD_LSB];
            user_parity_sel <= rmcfg_pkg::RST_SERIAL_AIR_CFG[
                                   rmcfg_pkg::PARITY_MSB:rmcfg_pkg::PARITY_LSB];
            air_rate_sel    <= rmcfg_pkg::RST_SERIAL_AIR_CFG[
                                   rmcfg_pkg::AIR_MSB:rmcfg_pkg::AIR_LSB];
            air_rate_bps    <= 17'd2400;
        end else begin
            radio_enable    <= !d.sleep && d.busy_n;
            addr_filter_en  <= {d.apl[0], d.apl[1]} !=
                               rmcfg_pkg::BROADCAST_ADDR;
            user_baud_sel   <= d.apl[2][rmcfg_pkg::BAUD_MSB:
                                        rmcfg_pkg::BAUD_LSB];
            user_parity_sel <= d.apl[2][rmcfg_pkg::PARITY_MSB:
                                        rmcfg_pkg::PARITY_LSB];
            air_rate_sel    <= d.apl[2][rmcfg_pkg::AIR_MSB:
                                        rmcfg_pkg::AIR_LSB];
            air_rate_bps    <= air_bps(d.apl[2][2:0]);
        end
    end

    assign link.dev_to_host_txd = q.txd;
    assign link.busy_n          = q.busy_n;
endmodule : rmcfg_device

// File: rtl/rmcfg_host.sv
// Host end: software drives mode pins and sends command bytes through a
// small register port; reply bytes and busy rising edges raise interrupts.
// Assumes device outputs are asynchronous to clk and get synchronised.
module rmcfg_host #(
    parameter int unsigned BIT_CYC = rmcfg_pkg::BIT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    rmcfg_if.host            link,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    output logic             irq
);
    // All host state in one record
    typedef struct packed {
        logic        sleep_req;
        logic [1:0]  rx_s;
        logic [1:0]  busy_s;
        logic        busy_prev;
        logic [2:0]  status;
        logic [2:0]  enable;
        logic [7:0]  rx_data;
        logic        rx_act;
        logic [15:0] rx_cnt;
        logic [3:0]  rx_bit;
        logic [7:0]  rx_sh;
        logic        tx_act;
        logic [15:0] tx_cnt;
        logic [3:0]  tx_bit;
        logic [9:0]  tx_sh;
        logic        txd;
        logic [7:0]  rdata;
        logic        irq;
    } rmcfg_host_t;

    rmcfg_host_t q, d;

    // Next-state logic
    always_comb begin
        logic [2:0] ev;
        d  = q;
        ev = 3'b000;
        d.rx_s   = {q.rx_s[0], link.dev_to_host_txd};
        d.busy_s = {q.busy_s[0], link.busy_n};
        d.busy_prev = q.busy_s[1];
        // Busy rising edge marks the end of reconfiguration
        ev[rmcfg_pkg::EV_READY] = q.busy_s[1] && !q.busy_prev;

        // Transmitter, 9600 8N1
        if (q.tx_act) begin
            d.txd = q.tx_sh[0];
            if (q.tx_cnt != 16'd0)
                d.tx_cnt = q.tx_cnt - 16'd1;
            else begin
                d.tx_cnt = 16'(BIT_CYC - 1);
                d.tx_sh  = {1'b1, q.tx_sh[9:1]};
                d.tx_bit = q.tx_bit + 4'd1;
                if (q.tx_bit == 4'd9) begin
                    d.tx_act = 1'b0;
                    ev[rmcfg_pkg::EV_TXDONE] = 1'b1;
                end
            end
        end else
            d.txd = 1'b1;
        // A byte written while busy is dropped; software polls the link reg
        if (reg_wr && reg_addr == rmcfg_pkg::HR_TXDATA && !q.tx_act) begin
            d.tx_sh  = {1'b1, reg_wdata, 1'b0};
            d.tx_act = 1'b1;
            d.tx_cnt = 16'(BIT_CYC - 1);
            d.tx_bit = 4'd0;
        end

        // Receiver, mid-bit sampling
        if (!q.rx_act) begin
            if (!q.rx_s[1]) begin
                d.rx_act = 1'b1;
                d.rx_cnt = 16'(BIT_CYC / 2);
                d.rx_bit = 4'd0;
            end
        end else if (q.rx_cnt != 16'd0)
            d.rx_cnt = q.rx_cnt - 16'd1;
        else begin
            d.rx_cnt = 16'(BIT_CYC - 1);
            d.rx_bit = q.rx_bit + 4'd1;
            if (q.rx_bit == 4'd0 && q.rx_s[1])
                d.rx_act = 1'b0;
            else if (q.rx_bit == 4'd9) begin
                d.rx_act = 1'b0;
                if (q.rx_s[1]) begin
                    d.rx_data = q.rx_sh;
                    ev[rmcfg_pkg::EV_RX] = 1'b1;
                end
            end else if (q.rx_bit != 4'd0)
                d.rx_sh = {q.rx_s[1], q.rx_sh[7:1]};
        end

        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                rmcfg_pkg::HR_CTRL:   d.sleep_req = reg_wdata[0];
                rmcfg_pkg::HR_ENABLE: d.enable = reg_wdata[2:0];
                rmcfg_pkg::HR_CLEAR:  d.status = q.status & ~reg_wdata[2:0];
                default: ;
            endcase
        end
        d.status = d.status | ev;   // Set wins over a same-cycle clear

        // Register reads, data valid the cycle after the strobe
        d.rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                rmcfg_pkg::HR_CTRL:   d.rdata = {7'd0, q.sleep_req};
                rmcfg_pkg::HR_RXDATA: d.rdata = q.rx_data;
                rmcfg_pkg::HR_STATUS: d.rdata = {5'd0, q.status};
                rmcfg_pkg::HR_ENABLE: d.rdata = {5'd0, q.enable};
                rmcfg_pkg::HR_LINK:   d.rdata = {6'd0, q.busy_s[1], q.tx_act};
                default:              d.rdata = 8'h00;
            endcase
        end
        d.irq = |(d.status & d.enable);
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q        <= '0;
            q.rx_s   <= 2'b11;
            q.busy_s <= 2'b11;
            q.busy_prev <= 1'b1;
            q.txd    <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign link.mode_select_low  = q.sleep_req; // Both high selects sleep
    assign link.mode_select_high = q.sleep_req;
    assign link.host_to_dev_txd  = q.txd;
    assign reg_rdata             = q.rdata;
    assign irq                   = q.irq;
endmodule : rmcfg_host

// File: sim/rmcfg_chk.sv
// Checker for the wires of the configuration link.
// Assumes one clk for both ends and rst synchronous, active high.
module rmcfg_chk #(
    parameter int unsigned BIT_CYC = rmcfg_pkg::BIT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mode_select_low,
    input wire logic mode_select_high,
    input wire logic host_to_dev_txd,
    input wire logic dev_to_host_txd,
    input wire logic busy_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wide enough for nine low bits at the full-length bit time
    logic [19:0] dlo_q; // Low run of device serial line
    logic [19:0] hlo_q; // Low run of host serial line
    logic [19:0] blo_q; // Low run of busy indicator
    logic        sleep; // Both mode pins high
    assign sleep = mode_select_low & mode_select_high;
    // Run counters; cleared in reset so old runs never leak through
    always_ff @(posedge clk) begin
        dlo_q <= (rst | dev_to_host_txd) ? 20'h0_0000 : dlo_q + 20'h0_0001;
        hlo_q <= (rst | host_to_dev_txd) ? 20'h0_0000 : hlo_q + 20'h0_0001;
        blo_q <= (rst | busy_n) ? 20'h0_0000 : blo_q + 20'h0_0001;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Busy indicator ends its low phase
    sequence s_busy_end;
        $rose(busy_n);
    endsequence
    a_busy_span: assert property (s_busy_end |->
        blo_q == 20'(rmcfg_pkg::RECFG_CYCLES))
        else $error("busy low span wrong");
    a_busy_cause: assert property ($fell(busy_n) |-> !sleep)
        else $error("busy fell while in sleep");
    a_dev_bits: assert property ($rose(dev_to_host_txd) |->
        (dlo_q % BIT_CYC) == 0)
        else $error("device bit length wrong");
    a_host_bits: assert property ($rose(host_to_dev_txd) |->
        (hlo_q % BIT_CYC) == 0)
        else $error("host bit length wrong");
    a_reply_sleep: assert property ($fell(dev_to_host_txd) |->
        sleep)
        else $error("reply outside sleep");
    a_reply_quiet: assert property ($fell(dev_to_host_txd) |->
        host_to_dev_txd && $past(host_to_dev_txd, 4))
        else $error("reply overlaps command");
    a_host_waits: assert property ($fell(host_to_dev_txd) |->
        busy_n)
        else $error("host sent while busy");
    a_reset_idle: assert property (disable iff (1'b0)
        rst |=> dev_to_host_txd && busy_n)
        else $error("lines not idle in reset");
endmodule // rmcfg_chk

// File: sim/test_radio_module_config_command_parser.sv
// Bench: host register port tasks send commands, replies are compared.
// Assumes shortened counts: MODE_CYC 200, BIT_CYC 16.
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module test_radio_module_config_command_parser;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] rmcfg_byte_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata, d;
    logic        irq, radio_enable, addr_filter_en;
    logic [2:0]  user_baud_sel, air_rate_sel;
    logic [1:0]  user_parity_sel;
    logic [16:0] air_rate_bps;
    logic [16:0] bps [8] = '{17'h0_0960, 17'h0_0960, 17'h0_0960,
        17'h0_12C0, 17'h0_2580, 17'h0_4B00, 17'h0_9600, 17'h0_F424};
    int          fail_count = 0;
    int          num_checks = 0;
    rmcfg_if link ();
    rmcfg_host #(.BIT_CYC(16)) i_rmcfg_host (.clk(clk), .rst(rst),
        .link(link), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    rmcfg_device #(.MODE_CYC(200), .BIT_CYC(16)) i_rmcfg_device (.clk(clk),
        .rst(rst), .link(link), .radio_enable(radio_enable),
        .addr_filter_en(addr_filter_en), .user_baud_sel(user_baud_sel),
        .user_parity_sel(user_parity_sel), .air_rate_sel(air_rate_sel),
        .air_rate_bps(air_rate_bps));
    rmcfg_chk #(.BIT_CYC(16)) i_rmcfg_chk (.clk(clk), .rst(rst),
        .mode_select_low(link.mode_select_low),
        .mode_select_high(link.mode_select_high),
        .host_to_dev_txd(link.host_to_dev_txd),
        .dev_to_host_txd(link.dev_to_host_txd), .busy_n(link.busy_n));
    // 100 MHz clock
    always #5 clk = ~clk;
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data are taken in the cycle after the strobe only
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Poll a status bit, bounded
    task automatic wait_ev(input int b);
        d = 8'h00;
        for (int k = 0; k < 400 && d[b] !== 1'b1; k++) rd(rmcfg_pkg::HR_STATUS);
        `CHK(d[b], 1'b1)
    endtask
    // Send command bytes, then take each reply byte on the interrupt
    task automatic xfer(input rmcfg_byte_t c[$], input rmcfg_byte_t e[$]);
        foreach (c[i]) begin
            wr(rmcfg_pkg::HR_TXDATA, c[i]);
            wait_ev(rmcfg_pkg::EV_TXDONE);
            wr(rmcfg_pkg::HR_CLEAR, 8'h02);
        end
        foreach (e[i]) begin
            for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge clk);
            `CHK(irq, 1'b1)
            rd(rmcfg_pkg::HR_RXDATA);
            `CHK(d, e[i])
            wr(rmcfg_pkg::HR_CLEAR, 8'h01);
            rd(rmcfg_pkg::HR_STATUS);
            `CHK(irq, 1'b0)
        end
    endtask
    // Verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Test sequence
    initial begin
        rmcfg_byte_t q[$];
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        wr(rmcfg_pkg::HR_ENABLE, 8'h01);
        rd(4'hF);
        `CHK(d, 8'h00)
        rd(rmcfg_pkg::HR_ENABLE);
        `CHK(d, 8'h01)
        rd(rmcfg_pkg::HR_LINK);
        `CHK(d, 8'h02)
        `CHK(addr_filter_en, 1'b1)
        wr(rmcfg_pkg::HR_CTRL, 8'h01);
        repeat (100) @(posedge clk);
        `CHK(radio_enable, 1'b1)
        repeat (200) @(posedge clk);
        `CHK(radio_enable, 1'b0)
        xfer('{8'hC1, 8'h00, 8'h03},
            '{8'hC1, 8'h00, 8'h03, 8'h00, 8'h00, 8'h62});
        $display("test reset read done");
        xfer('{8'hC0, 8'h00, 8'h02, 8'hFF, 8'hFF},
            '{8'hC1, 8'h00, 8'h02, 8'hFF, 8'hFF});
        `CHK(addr_filter_en, 1'b0)
        for (int i = 0; i < 8; i++) begin
            q = '{8'hC2, 8'h02, 8'h01, {i[2:0], i[1:0], i[2:0]}};
            xfer(q, '{8'hC1, 8'h02, 8'h01, q[3]});
            `CHK(air_rate_bps, bps[i])
            `CHK(user_baud_sel, i[2:0])
            `CHK(user_parity_sel, i[1:0])
        end
        $display("test writes done");
        xfer('{8'hAA}, '{8'hFF, 8'hFF, 8'hFF});
        xfer('{8'hC1, 8'h00, 8'h00}, '{8'hFF, 8'hFF, 8'hFF});
        xfer('{8'hC1, 8'h02, 8'h02}, '{8'hFF, 8'hFF, 8'hFF});
        $display("test errors done");
        wr(rmcfg_pkg::HR_CTRL, 8'h00);
        wait_ev(rmcfg_pkg::EV_READY);
        `CHK(irq, 1'b0)
        wr(rmcfg_pkg::HR_CLEAR, 8'h04);
        repeat (4) @(posedge clk);
        `CHK(radio_enable, 1'b1)
        `CHK(air_rate_sel, 3'h2)
        `CHK(user_baud_sel, 3'h3)
        wr(rmcfg_pkg::HR_CTRL, 8'h01);
        repeat (300) @(posedge clk);
        xfer('{8'hC1, 8'h00, 8'h03},
            '{8'hC1, 8'h00, 8'h03, 8'hFF, 8'hFF, 8'h62});
        $display("test wake done");
        results();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule // test_radio_module_config_command_parser
